// ===== hw/ras_node_pkg.sv
// constants and types of the fault injection node
`default_nettype none
package ras_node_pkg;

   // ****************************************
   // register selection
   // ****************************************
   localparam logic [15:0] RECORD_SEL_NODE = 16'h0000;
   localparam logic [2:0]  REG_MISC0       = 3'h0;
   localparam logic [2:0]  REG_MISC1       = 3'h1;
   localparam logic [2:0]  REG_CDN         = 3'h2;
   localparam logic [2:0]  REG_CTL         = 3'h3;
   localparam logic [2:0]  REG_FEAT        = 3'h4;

   // ****************************************
   // reset and fixed values
   // ****************************************
   localparam logic [31:0] MISC0_HI_RESET  = 32'h00000000;
   localparam logic [31:0] MISC0_LO_RESET  = 32'h00000000;
   localparam logic [31:0] MISC0_HI_MASK   = 32'h0000FFFF;
   localparam logic [31:0] CDN_RESET       = 32'h00000000;
   localparam logic [31:0] CTL_RESET       = 32'h00000000;
   localparam logic [31:0] CTL_WRITE_MASK  = 32'hC0001FE3;
   localparam logic [31:0] FEAT_VALUE      = 32'hC0000062;
   localparam logic [4:0]  SERR_INJ_TAG    = 5'h05;
   localparam logic [4:0]  SERR_INJ_DATA   = 5'h06;

   // ****************************************
   // control field positions
   // ****************************************
   localparam int CTL_RUN    = 31;
   localparam int CTL_RELOAD = 30;
   localparam int CTL_MV     = 12;
   localparam int CTL_OF     = 0;
   localparam int CTL_CE_LSB = 6;
   localparam int CTL_DE     = 5;
   localparam int CTL_UC     = 1;

   // ****************************************
   // syndrome field layout
   // ****************************************
   localparam int WAY_LSB     = 28;
   localparam int INDEX_LSB   = 6;
   localparam int INDEX_W     = 13;
   localparam int ARRAY_LSB   = 4;
   localparam int L2_SIZE_LOG = 9;
   localparam int L2_IDX_W    = L2_SIZE_LOG + 3;
   localparam int TQ_IDX_W    = INDEX_W - 8;

   localparam logic [3:0] UNIT_L1I   = 4'h1;
   localparam logic [3:0] UNIT_L2TLB = 4'h2;
   localparam logic [3:0] UNIT_L1D   = 4'h4;
   localparam logic [3:0] UNIT_L2    = 4'h8;
   localparam logic [1:0] ARR_L2_DATA = 2'h1;
   localparam logic [1:0] ARR_L2_TQ   = 2'h2;
   localparam logic [1:0] ARR_L1I_TAG = 2'h0;
   localparam logic [1:0] ARR_L1I_DAT = 2'h1;
   localparam logic [1:0] ARR_L1I_MOP = 2'h2;

   typedef enum logic [1:0] {DET_L1I, DET_L2TLB, DET_L1D, DET_L2} det_unit_t;
   typedef enum logic [1:0] {INJ_NONE, INJ_CE, INJ_DE, INJ_UC} inj_kind_t;

endpackage
`default_nettype wire

// ===== hw/node_links_if.sv
// links between the node and its counter and syndrome encoder
`timescale 1ns/1ps
`default_nettype none
interface countdown_if;
   import ras_node_pkg::*;
   logic        run_en;
   logic        reload_en;
   logic        start;
   logic [31:0] preset;
   logic        fire;
   logic        running;
   modport ctrl (output run_en, output reload_en, output start, output preset, input fire, input running);
   modport cnt  (input run_en, input reload_en, input start, input preset, output fire, output running);
endinterface

interface syndrome_if;
   import ras_node_pkg::*;
   det_unit_t   unit;
   logic [3:0]  hits;
   logic [12:0] index;
   logic [3:0]  way;
   logic [31:0] syndrome;
   modport src (output unit, output hits, output index, output way, input syndrome);
   modport enc (input unit, input hits, input index, input way, output syndrome);
endinterface
`default_nettype wire

// ===== hw/fault_countdown.sv
// error generation countdown counter
`timescale 1ns/1ps
`default_nettype none
module fault_countdown
   import ras_node_pkg::*;
(
   // clock and reset
   input  wire logic   clk_sys,
   input  wire logic   rst_b,
   // control link
   countdown_if.cnt    cd
);

   typedef struct packed
   {
      logic        running;
      logic [31:0] count;
   } cnt_state_t;

   cnt_state_t state_reg;
   cnt_state_t state_next;

   // ****************************************
   // count logic
   // ****************************************
   always_comb
   begin
      state_next = state_reg;
      if (!cd.run_en)
      begin
         state_next.running = 1'b0;
      end
      else if (cd.start)
      begin
         state_next.running = 1'b1;
         state_next.count   = cd.preset;
      end
      else if (state_reg.running)
      begin
         if (state_reg.count == 32'h00000000)
         begin
            if (cd.reload_en)
            begin
               state_next.count = cd.preset;
            end
            else
            begin
               state_next.running = 1'b0;
            end
         end
         else
         begin
            state_next.count = state_reg.count - 32'h00000001;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign cd.running = state_reg.running;
   assign cd.fire    = state_reg.running && cd.run_en && !cd.start && (state_reg.count == 32'h00000000);

endmodule
`default_nettype wire

// ===== hw/syndrome_encoder.sv
// builds the low word of the miscellaneous syndrome from a detector report
`timescale 1ns/1ps
`default_nettype none
module syndrome_encoder
   import ras_node_pkg::*;
(
   // detector link
   syndrome_if.enc  sy
);

   function automatic logic [12:0] keep_low(input logic [12:0] idx, input int width);
      logic [12:0] mask;
      mask = 13'h1FFF >> (INDEX_W - width);
      return idx & mask;
   endfunction

   function automatic logic [1:0] first_hit(input logic [3:0] hits);
      logic [1:0] code;
      code = 2'h3;
      if (hits[2]) code = 2'h2;
      if (hits[1]) code = 2'h1;
      if (hits[0]) code = 2'h0;
      return code;
   endfunction

   logic [3:0]  unit_code;
   logic [1:0]  array_code;
   logic [12:0] index_field;
   logic [3:0]  way_field;

   // ****************************************
   // field encoding
   // ****************************************
   always_comb
   begin
      array_code  = first_hit(sy.hits);
      index_field = sy.index;
      way_field   = sy.way;
      unit_code   = UNIT_L1I;
      case (sy.unit)
         DET_L1I:
         begin
            unit_code = UNIT_L1I;
            if (sy.hits[1])
               array_code = ARR_L1I_DAT;
            else if (sy.hits[0])
               array_code = ARR_L1I_TAG;
            else
               array_code = ARR_L1I_MOP;
         end
         DET_L2TLB: unit_code = UNIT_L2TLB;
         DET_L1D:   unit_code = UNIT_L1D;
         DET_L2:
         begin
            unit_code = UNIT_L2;
            if (array_code != 2'h0)
               way_field = 4'h0;
            if (array_code == ARR_L2_DATA)
               index_field = keep_low(sy.index, L2_IDX_W);
            else if (array_code == ARR_L2_TQ)
               index_field = keep_low(sy.index, TQ_IDX_W);
            else if (array_code == 2'h3)
               index_field = 13'h0000;
         end
         default: unit_code = 4'h0;
      endcase
   end

   assign sy.syndrome = {way_field, 9'h000, index_field, array_code, unit_code};

endmodule
`default_nettype wire

// ===== hw/ras_fault_injection_node.sv
// error record node with pseudo fault injection
//
// Operation
// - L2 data RAM index reports line index low bits, higher index bits zero.
// - L2 transaction queue index holds entry number, top eight bits unused.
// - L2 array code: tag, data, queue data, interconnect slave error ascending.
// - L1 data array code: tag copy0, tag copy1, data RAM, tag copy2.
// - L1 instruction array: tag 0, data 1, micro-op 2; data wins.
// - unit field one-hot: L1I, L2 TLB, L1D, L2 cache.
// - syndrome upper word clears on reset; lower word undefined.
// - second miscellaneous syndrome register reads zero, ignores writes.
// - 32-bit read-write countdown preset feeds the generation counter.
// - run enable bit 31 clear disables counter; setting loads preset, starts.
// - bit 30 at zero: clear stops counter, set reloads and continues.
// - bit 12 is misc-valid value written for injected record.
// - bit 11 is address-valid value written for injected record.
// - bits 10,9,8 are poison, reported, critical values for injected record.
// - bit 0 is overflow value written for injected record.
// - bits 7:6 select corrected fault type injected at counter zero.
// - bit 5 enables deferred error injection at counter trigger.
// - bits 4,3,2 enable latent, signaled, unrecoverable injection; here they are not writable and read zero.
// - bit 1 enables uncontainable error injection at counter trigger.
// - type and syndrome controls undefined on cold reset, kept on recovery.
// - unsupported controls and bits 29:13 read zero, ignore writes.
// - only restart, corrected, deferred, uncontainable supported; feature reads 0xC0000062.
// - injected errors recorded with code 0x5 tag, 0x6 data.
// - injection control register reads zero after reset.
`timescale 1ns/1ps
`default_nettype none
module ras_fault_injection_node
   import ras_node_pkg::*;
(
   // clock and resets
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        recovery_rst,
   // selected-record register port
   input  wire logic [15:0] record_sel,
   input  wire logic        sysreg_rd,
   input  wire logic        sysreg_wr,
   input  wire logic [2:0]  sysreg_id,
   input  wire logic [63:0] sysreg_wdata,
   output logic      [63:0] sysreg_rdata,
   output logic             sysreg_ack,
   // detector reports
   input  wire logic        det_valid,
   input  wire det_unit_t   det_unit,
   input  wire logic [3:0]  det_hits,
   input  wire logic [12:0] det_index,
   input  wire logic [3:0]  det_way,
   // injection target and record output
   input  wire logic        inject_to_tag,
   output logic             inj_valid,
   output inj_kind_t        inj_kind,
   output logic      [1:0]  inj_ce_type,
   output logic      [4:0]  inj_serr,
   output logic      [5:0]  inj_status_flags,
   // counter state
   output logic             countdown_active
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed
   {
      logic [63:0] misc0;
      logic [31:0] countdown_preset;
      logic [31:0] ctl;
      logic        run_q;
      logic [63:0] rdata;
      logic        ack;
      logic        inj_valid;
      inj_kind_t   inj_kind;
      logic [1:0]  inj_ce;
      logic [4:0]  inj_serr;
      logic [5:0]  inj_flags;
      logic        active;
   } node_state_t;

   node_state_t state_reg;
   node_state_t state_next;

   countdown_if cd ();
   syndrome_if  sy ();

   logic sel_ok;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] ctl_legal(input logic [31:0] value);
      return value & CTL_WRITE_MASK;
   endfunction

   function automatic inj_kind_t inject_pick(input logic [31:0] ctl);
      inj_kind_t kind;
      kind = INJ_NONE;
      if (ctl[CTL_CE_LSB +: 2] != 2'h0)
         kind = INJ_CE;
      if (ctl[CTL_DE])
         kind = INJ_DE;
      if (ctl[CTL_UC])
         kind = INJ_UC;
      return kind;
   endfunction

   // ****************************************
   // sub-blocks
   // ****************************************
   fault_countdown u_countdown
   (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .cd      (cd)
   );

   syndrome_encoder u_encoder
   (
      .sy (sy)
   );

   assign cd.run_en    = state_reg.ctl[CTL_RUN];
   assign cd.reload_en = state_reg.ctl[CTL_RELOAD];
   assign cd.start     = state_reg.ctl[CTL_RUN] & ~state_reg.run_q;
   assign cd.preset    = state_reg.countdown_preset;

   assign sy.unit  = det_unit;
   assign sy.hits  = det_hits;
   assign sy.index = det_index;
   assign sy.way   = det_way;

   assign sel_ok = (record_sel == RECORD_SEL_NODE);

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      state_next           = state_reg;
      state_next.run_q     = state_reg.ctl[CTL_RUN];
      state_next.ack       = 1'b0;
      state_next.inj_valid = 1'b0;
      state_next.active    = cd.running;

      // register writes
      if (sysreg_wr && sel_ok)
      begin
         case (sysreg_id)
            REG_MISC0:
            begin
               state_next.misc0 = {sysreg_wdata[63:32] & MISC0_HI_MASK, sysreg_wdata[31:0]};
            end
            REG_CDN:
            begin
               state_next.countdown_preset = sysreg_wdata[31:0];
            end
            REG_CTL:
            begin
               state_next.ctl = ctl_legal(sysreg_wdata[31:0]);
            end
            default:
            begin
               state_next.misc0 = state_next.misc0;
            end
         endcase
      end

      // detector report wins over a write in the same cycle for the low word only; the upper word still takes the write
      if (det_valid)
      begin
         state_next.misc0[31:0] = sy.syndrome;
      end

      // recovery reset stops the counter, keeps type and syndrome fields
      if (recovery_rst)
      begin
         state_next.ctl[CTL_RUN] = 1'b0;
      end

      // register reads
      if (sysreg_rd)
      begin
         state_next.ack   = 1'b1;
         state_next.rdata = 64'h0000000000000000;
         if (sel_ok)
         begin
            case (sysreg_id)
               REG_MISC0: state_next.rdata = state_reg.misc0;
               REG_MISC1: state_next.rdata = 64'h0000000000000000;
               REG_CDN:   state_next.rdata = {32'h00000000, state_reg.countdown_preset};
               REG_CTL:   state_next.rdata = {32'h00000000, state_reg.ctl};
               REG_FEAT:  state_next.rdata = {32'h00000000, FEAT_VALUE};
               default:   state_next.rdata = 64'h0000000000000000;
            endcase
         end
      end

      // injection at counter trigger
      if (cd.fire && (inject_pick(state_reg.ctl) != INJ_NONE))
      begin
         state_next.inj_valid = 1'b1;
         state_next.inj_kind  = inject_pick(state_reg.ctl);
         state_next.inj_ce    = state_reg.ctl[CTL_CE_LSB +: 2];
         state_next.inj_serr  = inject_to_tag ? SERR_INJ_TAG : SERR_INJ_DATA;
         state_next.inj_flags = {state_reg.ctl[CTL_MV -: 5], state_reg.ctl[CTL_OF]};
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg           <= '0;
         state_reg.misc0     <= {MISC0_HI_RESET, MISC0_LO_RESET};
         state_reg.countdown_preset       <= CDN_RESET;
         state_reg.ctl       <= CTL_RESET;
         state_reg.inj_kind  <= INJ_NONE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign sysreg_rdata     = state_reg.rdata;
   assign sysreg_ack       = state_reg.ack;
   assign inj_valid        = state_reg.inj_valid;
   assign inj_kind         = state_reg.inj_kind;
   assign inj_ce_type      = state_reg.inj_ce;
   assign inj_serr         = state_reg.inj_serr;
   assign inj_status_flags = state_reg.inj_flags;
   assign countdown_active = state_reg.active;

endmodule
`default_nettype wire

// ===== verif/ras_node_checker.sv
// assertion checker of the fault injection node ports
`timescale 1ns/1ps
`default_nettype none
module ras_node_checker
   import ras_node_pkg::*;
(
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rst_b,
   // register port
   input wire logic [15:0] record_sel,
   input wire logic        sysreg_rd,
   input wire logic        sysreg_wr,
   input wire logic [2:0]  sysreg_id,
   input wire logic [63:0] sysreg_wdata,
   input wire logic [63:0] sysreg_rdata,
   input wire logic        sysreg_ack,
   // injection
   input wire logic        inject_to_tag,
   input wire logic        inj_valid,
   input wire inj_kind_t   inj_kind,
   input wire logic [4:0]  inj_serr
);
   // ****************************************
   // assertions
   // ****************************************
   logic sel_ok;
   assign sel_ok = (record_sel == RECORD_SEL_NODE);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   chk_ack_after_read: assert property (sysreg_rd |=> sysreg_ack)
      else $error("read got no answer");
   chk_ack_needs_read: assert property (sysreg_ack |-> $past(sysreg_rd))
      else $error("answer without read");
   chk_feature_value: assert property (sysreg_rd && sel_ok && sysreg_id == REG_FEAT |=> sysreg_rdata == {32'h0, FEAT_VALUE})
      else $error("feature value wrong");
   chk_misc1_reads_zero: assert property (sysreg_rd && sysreg_id == REG_MISC1 |=> sysreg_rdata == 64'h0)
      else $error("second misc not zero");
   chk_misc0_top_zero: assert property (sysreg_rd && sysreg_id == REG_MISC0 |=> sysreg_rdata[63:48] == 16'h0)
      else $error("syndrome top bits set");
   chk_inject_code: assert property (inj_valid |-> inj_serr == ($past(inject_to_tag) ? SERR_INJ_TAG : SERR_INJ_DATA))
      else $error("injected code wrong");
   chk_inject_kind_set: assert property (inj_valid |-> inj_kind != INJ_NONE)
      else $error("injection without kind");
   chk_stop_at_once: assert property (sysreg_wr && sel_ok && sysreg_id == REG_CTL && !sysreg_wdata[31] |-> ##3 !inj_valid [*4])
      else $error("injection after stop");
   cov_ce: cover property (inj_valid && inj_kind == INJ_CE);
   cov_de: cover property (inj_valid && inj_kind == INJ_DE);
   cov_uc: cover property (inj_valid && inj_kind == INJ_UC);
endmodule

bind ras_fault_injection_node ras_node_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .record_sel(record_sel),
   .sysreg_rd(sysreg_rd), .sysreg_wr(sysreg_wr), .sysreg_id(sysreg_id), .sysreg_wdata(sysreg_wdata),
   .sysreg_rdata(sysreg_rdata), .sysreg_ack(sysreg_ack), .inject_to_tag(inject_to_tag),
   .inj_valid(inj_valid), .inj_kind(inj_kind), .inj_serr(inj_serr));
`default_nettype wire

// ===== verif/ras_fault_injection_node_tb.sv
// self-checking bench of the fault injection node
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module ras_fault_injection_node_tb;
   import ras_node_pkg::*;
   // ****************************************
   // signals and design
   // ****************************************
   logic        clk_sys = 1'b0, rst_b = 1'b0, recovery_rst = 1'b0;
   logic [15:0] record_sel = 16'h0;
   logic        sysreg_rd = 1'b0, sysreg_wr = 1'b0, det_valid = 1'b0, inject_to_tag = 1'b1;
   logic [2:0]  sysreg_id = 3'h0;
   logic [63:0] sysreg_wdata = 64'h0, sysreg_rdata, v;
   logic        sysreg_ack, inj_valid, countdown_active;
   det_unit_t   det_unit = DET_L1I;
   logic [3:0]  det_hits = 4'h0, det_way = 4'h0;
   logic [12:0] det_index = 13'h0;
   inj_kind_t   inj_kind;
   logic [1:0]  inj_ce_type;
   logic [4:0]  inj_serr;
   logic [5:0]  inj_status_flags;
   int          num_errors = 0, checks = 0, inj_count = 0, n;
   logic [63:0] wr_tab [6] = '{64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF,
                               64'h7FFF_FFFF, 64'hFFFF_FFFF, 64'hFFFF_FFFF};
   logic [63:0] ex_tab [6] = '{64'h0000_FFFF_FFFF_FFFF, 64'h0, 64'hFFFF_FFFF, 64'h4000_1FE3, {32'h0, FEAT_VALUE}, 64'h0};
   logic [31:0] ctl_tab [3] = '{32'h8000_1541, 32'h8000_0AA0, 32'h8000_00E2};
   inj_kind_t   kind_tab [3] = '{INJ_CE, INJ_DE, INJ_UC};

   ras_fault_injection_node dut (.clk_sys, .rst_b, .recovery_rst, .record_sel, .sysreg_rd, .sysreg_wr, .sysreg_id,
      .sysreg_wdata, .sysreg_rdata, .sysreg_ack, .det_valid, .det_unit, .det_hits, .det_index, .det_way,
      .inject_to_tag, .inj_valid, .inj_kind, .inj_ce_type, .inj_serr, .inj_status_flags, .countdown_active);

   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
      if (inj_valid === 1'b1)
         inj_count <= inj_count + 1;

   // ****************************************
   // access tasks
   // ****************************************
   task automatic wr(input logic [2:0] id, input logic [63:0] d);
      @(negedge clk_sys);
      sysreg_wr = 1'b1;
      sysreg_id = id;
      sysreg_wdata = d;
      @(negedge clk_sys);
      sysreg_wr = 1'b0;
   endtask

   task automatic rd(input logic [2:0] id, output logic [63:0] q);
      int k;
      @(negedge clk_sys);
      sysreg_rd = 1'b1;
      sysreg_id = id;
      @(negedge clk_sys);
      sysreg_rd = 1'b0;
      for (k = 0; k < 3 && sysreg_ack !== 1'b1; k++)
         @(negedge clk_sys);
      `CHK(sysreg_ack, 1'b1)
      q = sysreg_rdata;
   endtask

   task automatic det(input det_unit_t u, input logic [3:0] h, w, input logic [12:0] i, input logic [31:0] e);
      @(negedge clk_sys);
      det_valid = 1'b1;
      det_unit = u;
      det_hits = h;
      det_way = w;
      det_index = i;
      @(negedge clk_sys);
      det_valid = 1'b0;
      rd(REG_MISC0, v);
      `CHK(v, {32'h0, e})
   endtask

   task automatic run(input logic [31:0] p, c);
      wr(REG_CTL, 64'h0);
      wr(REG_CDN, {32'h0, p});
      wr(REG_CTL, {32'h0, c});
      repeat (p + 1) @(negedge clk_sys);
      `CHK(inj_valid, 1'b0)
      @(negedge clk_sys);
      `CHK(inj_valid, 1'b1)
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   function automatic logic [31:0] mk(logic [3:0] w, logic [12:0] i, logic [1:0] a, logic [3:0] u);
      return {w, 9'h0, i, a, u};
   endfunction

   // ****************************************
   // tests
   // ****************************************
   initial
   begin
      #100000;
      num_errors++;
      conclude();
   end

   initial
   begin
      repeat (12) @(negedge clk_sys);
      rst_b = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         rd(i[2:0], v);
         `CHK(v, (i == 4) ? {32'h0, FEAT_VALUE} : 64'h0)
      end
      for (int i = 0; i < 6; i++)
         wr(i[2:0], wr_tab[i]);
      for (int i = 0; i < 6; i++)
      begin
         rd(i[2:0], v);
         `CHK(v, ex_tab[i])
      end
      record_sel = 16'h0001;
      rd(REG_FEAT, v);
      `CHK(v, 64'h0)
      wr(REG_CDN, 64'h5);
      record_sel = 16'h0000;
      rd(REG_CDN, v);
      `CHK(v[31:0], 32'hFFFF_FFFF)
      wr(REG_MISC0, 64'h0);
      det(DET_L2, 4'h2, 4'hF, 13'h1FFF, mk(4'h0, 13'h0FFF, 2'h1, 4'h8));
      det(DET_L2, 4'h4, 4'hF, 13'h1FFF, mk(4'h0, 13'h001F, 2'h2, 4'h8));
      det(DET_L2, 4'h1, 4'h3, 13'h0155, mk(4'h3, 13'h0155, 2'h0, 4'h8));
      det(DET_L2, 4'h8, 4'h3, 13'h0123, mk(4'h0, 13'h0000, 2'h3, 4'h8));
      det(DET_L1D, 4'h8, 4'h2, 13'h00AB, mk(4'h2, 13'h00AB, 2'h3, 4'h4));
      det(DET_L1I, 4'h3, 4'h1, 13'h0042, mk(4'h1, 13'h0042, 2'h1, 4'h1));
      det(DET_L1I, 4'h4, 4'h1, 13'h0042, mk(4'h1, 13'h0042, 2'h2, 4'h1));
      det(DET_L2TLB, 4'h1, 4'h5, 13'h0007, mk(4'h5, 13'h0007, 2'h0, 4'h2));
      for (int k = 0; k < 3; k++)
      begin
         inject_to_tag = k[0];
         run(32'd3, ctl_tab[k]);
         `CHK(inj_kind, kind_tab[k])
         `CHK(inj_ce_type, ctl_tab[k][7:6])
         `CHK(inj_status_flags, {ctl_tab[k][12:8], ctl_tab[k][0]})
         `CHK(inj_serr, k[0] ? SERR_INJ_TAG : SERR_INJ_DATA)
         n = inj_count;
         repeat (10) @(negedge clk_sys);
         `CHK(inj_count, n + 1)
      end
      run(32'd1, 32'hC000_0040);
      @(negedge clk_sys);
      `CHK(inj_valid, 1'b0)
      @(negedge clk_sys);
      `CHK(inj_valid, 1'b1)
      wr(REG_CTL, 64'h0);
      repeat (2) @(negedge clk_sys);
      n = inj_count;
      wr(REG_CDN, 64'h2);
      wr(REG_CTL, 64'h8000_0000);
      repeat (10) @(negedge clk_sys);
      `CHK(inj_count, n)
      wr(REG_CTL, 64'h0);
      wr(REG_CDN, 64'd20);
      wr(REG_CTL, 64'h8000_0002);
      repeat (5) @(negedge clk_sys);
      `CHK(countdown_active, 1'b1)
      wr(REG_CTL, 64'h0);
      repeat (30) @(negedge clk_sys);
      `CHK(inj_count, n)
      wr(REG_CDN, 64'd100);
      wr(REG_CTL, 64'hFFFF_FFFF_FFFF_FFFF);
      recovery_rst = 1'b1;
      @(negedge clk_sys);
      recovery_rst = 1'b0;
      rd(REG_CTL, v);
      `CHK(v[31:0], 32'h4000_1FE3)
      repeat (120) @(negedge clk_sys);
      `CHK(inj_count, n)
      conclude();
   end
endmodule
`default_nettype wire
